// file: qdac_ctrl.sv
// Quad converter serial load control with pin sampling, frame decode and AXI4-Lite registers.
//
// Overview of operation
// - Four channels, each input and converter register.
// - Frame select low frames next 24 bits.
// - Serial input sampled on serial clock fall.
// - Input shift register is 24 bits wide.
// - Serial output launched on serial clock rise.
// - Serial output serves readback or daisy chain.
// - Load pin has asynchronous and synchronous modes.
// - Load low copies pending inputs to converters.
// - Load pin may be tied low permanently.
// - Span select sets all outputs' span.
// - Reset pin acts on falling edge, clock-free.
// - Load pulses ignored while reset pin low.
// - Reset loads both register sets to level.
// - Power-on waits while reset pin held low.
// - Power-up level: low zero, high midscale.
// - Zero scale all zeros, full scale ones.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module qdac_ctrl (
	input  wire logic                   core_clk,           // System clock, 40 MHz.
	input  wire logic                   arst_n,             // Asynchronous reset, active low.
	input  wire logic                   serial_clk,         // Serial clock pin.
	input  wire logic                   frame_sel_n,        // Frame select pin, active low.
	input  wire logic                   serial_in,          // Serial data input pin.
	input  wire logic                   load_outputs_n,     // Load pin, active low.
	input  wire logic                   clear_n,            // Reset pin, active low.
	input  wire logic                   reset_level_select, // Reset level, high for midscale.
	input  wire logic                   span_select,        // Span pin, high for double span.
	output logic                        serial_out,         // Serial data output pin.
	output qdac_pkg::qdac_codes_t       dac_codes,          // Converter register codes A to D.
	output logic                        span_double,        // Double span selected.
	input  wire qdac_pkg::qdac_axi_req_s axi_req,           // AXI4-Lite master signals.
	output qdac_pkg::qdac_axi_rsp_s     axi_rsp             // AXI4-Lite slave signals.
);

	// Copies each masked channel from source to destination.
	function automatic qdac_pkg::qdac_codes_t copy_masked(
		input qdac_pkg::qdac_codes_t dst,
		input qdac_pkg::qdac_codes_t src,
		input logic [3:0]            mask
	);
		qdac_pkg::qdac_codes_t res;
		res = dst;
		for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
			if (mask[i]) begin
				res[i] = src[i];
			end
		end
		return res;
	endfunction : copy_masked

	// True when a byte offset names a register of this block.
	function automatic logic reg_mapped(input logic [31:0] addr);
		logic [7:0] ofs;
		ofs = addr[7:0];
		return (addr[31:8] == 24'h00_0000) && (ofs[1:0] == 2'h0)
			&& ((ofs == qdac_pkg::OFS_CTRL) || (ofs == qdac_pkg::OFS_STATUS)
			|| (ofs == qdac_pkg::OFS_FRAME)
			|| (ofs[7:4] == qdac_pkg::OFS_INPUT[7:4])
			|| (ofs[7:4] == qdac_pkg::OFS_DAC[7:4]));
	endfunction : reg_mapped

	logic [6:0]             pin_meta_reg;
	logic [6:0]             pin_sync_reg;
	logic [6:0]             pin_prev_reg;
	logic [6:0]             pin_raw;
	qdac_pkg::qdac_state_e  state_reg;
	qdac_pkg::qdac_state_e  state_next;
	logic [23:0]            shift_reg;
	logic [4:0]             bit_cnt_reg;
	logic [23:0]            rb_shift_reg;
	logic [1:0]             rb_sel_reg;
	logic                   rb_armed_reg;
	logic [23:0]            last_frame_reg;
	logic [7:0]             frame_cnt_reg;
	qdac_pkg::qdac_codes_t  input_reg;
	qdac_pkg::qdac_codes_t  input_next;
	qdac_pkg::qdac_codes_t  dac_reg;
	qdac_pkg::qdac_codes_t  dac_next;
	logic [3:0]             pend_reg;
	logic [3:0]             pend_next;
	logic [1:0]             ctrl_reg;
	logic                   serial_out_reg;
	logic                   span_reg;

	// Edges and levels of the sampled pins.
	wire sclk_fall   = pin_prev_reg[qdac_pkg::PIN_SCLK] & ~pin_sync_reg[qdac_pkg::PIN_SCLK];
	wire sclk_rise   = ~pin_prev_reg[qdac_pkg::PIN_SCLK] & pin_sync_reg[qdac_pkg::PIN_SCLK];
	wire frame_start = pin_prev_reg[qdac_pkg::PIN_FS] & ~pin_sync_reg[qdac_pkg::PIN_FS];
	wire frame_stop  = ~pin_prev_reg[qdac_pkg::PIN_FS] & pin_sync_reg[qdac_pkg::PIN_FS];
	wire frame_act   = ~pin_sync_reg[qdac_pkg::PIN_FS];
	wire clear_fall  = pin_prev_reg[qdac_pkg::PIN_CLR] & ~pin_sync_reg[qdac_pkg::PIN_CLR];
	wire clear_low   = ~pin_sync_reg[qdac_pkg::PIN_CLR];
	wire load_low    = ~pin_sync_reg[qdac_pkg::PIN_LOAD];
	wire running     = (state_reg == qdac_pkg::QDAC_ST_RUN);

	// Frame field decode; a frame counts only with at least 24 falls seen.
	wire        frame_ok   = frame_stop & running & (bit_cnt_reg == qdac_pkg::FRAME_LEN);
	wire [3:0]  frame_cmd  = shift_reg[qdac_pkg::CMD_MSB:qdac_pkg::CMD_LSB];
	wire [3:0]  frame_chan = shift_reg[qdac_pkg::CHAN_MSB:qdac_pkg::CHAN_LSB];
	wire [15:0] frame_data = shift_reg[qdac_pkg::DATA_MSB:0];
	wire        do_write   = frame_ok & ((frame_cmd == qdac_pkg::CMD_WRITE_INPUT)
		| (frame_cmd == qdac_pkg::CMD_WRITE_UPDATE));
	wire        do_update  = frame_ok & ((frame_cmd == qdac_pkg::CMD_UPDATE_DAC)
		| (frame_cmd == qdac_pkg::CMD_WRITE_UPDATE));
	wire        load_sync  = ctrl_reg[qdac_pkg::CTRL_SYNC_BIT];
	wire        daisy_mode = ctrl_reg[qdac_pkg::CTRL_DAISY_BIT];

	wire [15:0] reset_code = pin_sync_reg[qdac_pkg::PIN_LEVEL] ? qdac_pkg::MID_CODE
		: qdac_pkg::ZERO_CODE;
	wire qdac_pkg::qdac_codes_t reset_codes = {qdac_pkg::NUM_CH{reset_code}};

	// Readback word for the next frame; the unused top byte shifts out as zero.
	wire [23:0] rb_word = {8'h00, input_reg[rb_sel_reg]};

	assign pin_raw = {span_select, reset_level_select, clear_n, load_outputs_n,
		serial_in, frame_sel_n, serial_clk};

	// Every pin crosses through two flip-flops; the second stage and a third, kept for edge detection, feed logic.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta_reg <= qdac_pkg::PIN_IDLE;
			pin_sync_reg <= qdac_pkg::PIN_IDLE;
			pin_prev_reg <= qdac_pkg::PIN_IDLE;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	// Power-on waits for the reset pin to be high, then takes the strap level once.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			qdac_pkg::QDAC_ST_POR: begin
				if (!clear_low) begin
					state_next = qdac_pkg::QDAC_ST_RUN;
				end
			end
			qdac_pkg::QDAC_ST_RUN: begin
				state_next = qdac_pkg::QDAC_ST_RUN;
			end
			default: begin
				state_next = qdac_pkg::QDAC_ST_POR;
			end
		endcase
	end

	// Next values of the input, converter and pending sets.
	always_comb begin
		input_next = input_reg;
		dac_next   = dac_reg;
		pend_next  = pend_reg;
		if (!running) begin
			if (!clear_low) begin
				input_next = reset_codes;
				dac_next   = reset_codes;
				pend_next  = 4'h0;
			end
		end else if (clear_fall) begin
			input_next = reset_codes;
			dac_next   = reset_codes;
			pend_next  = 4'h0;
		end else begin
			if (do_write) begin
				input_next = copy_masked(input_next, {qdac_pkg::NUM_CH{frame_data}},
					frame_chan);
				pend_next  = pend_next | frame_chan;
			end
			if (do_update) begin
				dac_next  = copy_masked(dac_next, input_next, frame_chan);
				pend_next = pend_next & ~frame_chan;
			end
			if (!clear_low && load_low && (!load_sync || frame_ok)) begin
				dac_next  = copy_masked(dac_next, input_next, pend_next);
				pend_next = 4'h0;
			end
		end
	end

	// Channel state and power-on sequencer.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= qdac_pkg::QDAC_ST_POR;
			input_reg <= '0;
			dac_reg   <= '0;
			pend_reg  <= 4'h0;
		end else begin
			state_reg <= state_next;
			input_reg <= input_next;
			dac_reg   <= dac_next;
			pend_reg  <= pend_next;
		end
	end

	// Input shift register and bit counter; extra falls beyond 24 are ignored.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg   <= 24'h00_0000;
			bit_cnt_reg <= 5'h00;
		end else if (frame_start) begin
			bit_cnt_reg <= 5'h00;
		end else if (sclk_fall && frame_act && (bit_cnt_reg != qdac_pkg::FRAME_LEN)) begin
			shift_reg   <= {shift_reg[22:0], pin_sync_reg[qdac_pkg::PIN_SIN]};
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// Readback selection and the word shifted out during the following frame.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rb_shift_reg <= 24'h00_0000;
			rb_sel_reg   <= 2'h0;
			rb_armed_reg <= 1'b0;
		end else if (frame_ok && (frame_cmd == qdac_pkg::CMD_READBACK)) begin
			rb_sel_reg   <= frame_chan[1:0];
			rb_armed_reg <= 1'b1;
		end else if (frame_start) begin
			rb_shift_reg <= rb_armed_reg ? rb_word : 24'h00_0000;
			rb_armed_reg <= 1'b0;
		end else if (sclk_fall && frame_act) begin
			rb_shift_reg <= {rb_shift_reg[22:0], 1'b0};
		end
	end

	// Serial output; the first bit is presented at frame start, before the first fall.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			serial_out_reg <= 1'b0;
		end else if (frame_start) begin
			serial_out_reg <= daisy_mode ? shift_reg[23] : rb_word[23];
		end else if (sclk_rise && frame_act) begin
			serial_out_reg <= daisy_mode ? shift_reg[23] : rb_shift_reg[23];
		end
	end

	// Span and frame bookkeeping.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			span_reg       <= 1'b0;
			last_frame_reg <= 24'h00_0000;
			frame_cnt_reg  <= 8'h00;
		end else begin
			span_reg <= pin_sync_reg[qdac_pkg::PIN_SPAN];
			if (frame_ok) begin
				last_frame_reg <= shift_reg;
				frame_cnt_reg  <= frame_cnt_reg + 8'h01;
			end
		end
	end

	assign serial_out  = serial_out_reg;
	assign dac_codes   = dac_reg;
	assign span_double = span_reg;

	// AXI4-Lite slave state.
	logic        aw_have_reg;
	logic        w_have_reg;
	logic [31:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rd_mux;

	// Handshakes and the write commit, which waits for address and data both.
	wire aw_hs   = axi_req.awvalid & awready_reg;
	wire w_hs    = axi_req.wvalid & wready_reg;
	wire b_hs    = bvalid_reg & axi_req.bready;
	wire ar_hs   = axi_req.arvalid & arready_reg;
	wire r_hs    = rvalid_reg & axi_req.rready;
	wire wr_go   = aw_have_reg & w_have_reg & ~bvalid_reg;
	wire wr_ctrl = wr_go & reg_mapped(awaddr_reg) & (awaddr_reg[7:0] == qdac_pkg::OFS_CTRL)
		& wstrb_reg[0];
	wire [7:0] rd_ofs = axi_req.araddr[7:0];

	// Read data selection on the low address byte; offsets matching no register or range read as zero, and unmapped addresses get an error response.
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (rd_ofs == qdac_pkg::OFS_CTRL) begin
			rd_mux = {30'h0000_0000, ctrl_reg};
		end else if (rd_ofs == qdac_pkg::OFS_STATUS) begin
			rd_mux = {16'h0000, frame_cnt_reg, pend_reg, clear_low, span_reg, 1'b0, running};
		end else if (rd_ofs == qdac_pkg::OFS_FRAME) begin
			rd_mux = {8'h00, last_frame_reg};
		end else if (rd_ofs[7:4] == qdac_pkg::OFS_INPUT[7:4]) begin
			rd_mux = {16'h0000, input_reg[rd_ofs[3:2]]};
		end else if (rd_ofs[7:4] == qdac_pkg::OFS_DAC[7:4]) begin
			rd_mux = {16'h0000, dac_reg[rd_ofs[3:2]]};
		end
	end

	// Write channel: one write in flight, readies return after the response is taken.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= 32'h0000_0000;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= qdac_pkg::RESP_OKAY;
			ctrl_reg    <= qdac_pkg::CTRL_RESET;
		end else begin
			if (aw_hs) begin
				aw_have_reg <= 1'b1;
				awaddr_reg  <= axi_req.awaddr;
				awready_reg <= 1'b0;
			end
			if (w_hs) begin
				w_have_reg <= 1'b1;
				wdata_reg  <= axi_req.wdata;
				wstrb_reg  <= axi_req.wstrb;
				wready_reg <= 1'b0;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= reg_mapped(awaddr_reg) ? qdac_pkg::RESP_OKAY
					: qdac_pkg::RESP_SLVERR;
			end
			if (wr_ctrl) begin
				ctrl_reg <= wdata_reg[1:0];
			end
			if (b_hs) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Read channel: data is captured at the address handshake and answered next cycle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= qdac_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_mux;
			rresp_reg   <= reg_mapped(axi_req.araddr) ? qdac_pkg::RESP_OKAY
				: qdac_pkg::RESP_SLVERR;
		end else if (r_hs) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	assign axi_rsp.awready = awready_reg;
	assign axi_rsp.wready  = wready_reg;
	assign axi_rsp.bvalid  = bvalid_reg;
	assign axi_rsp.bresp   = bresp_reg;
	assign axi_rsp.arready = arready_reg;
	assign axi_rsp.rvalid  = rvalid_reg;
	assign axi_rsp.rdata   = rdata_reg;
	assign axi_rsp.rresp   = rresp_reg;

endmodule : qdac_ctrl

// file: qdac_pkg.sv
// Shared constants, types and register map for the quad converter serial load control.
package qdac_pkg;

	// Frame and channel geometry.
	localparam int unsigned NUM_CH     = 4;
	localparam int unsigned CODE_BITS  = 16;
	localparam int unsigned FRAME_BITS = 24;
	localparam logic [4:0]  FRAME_LEN  = 5'h18;

	// Frame field layout: command, channel field, data code.
	localparam int unsigned CMD_MSB  = 23;
	localparam int unsigned CMD_LSB  = 20;
	localparam int unsigned CHAN_MSB = 19;
	localparam int unsigned CHAN_LSB = 16;
	localparam int unsigned DATA_MSB = 15;

	// Frame commands.
	localparam logic [3:0] CMD_WRITE_INPUT  = 4'h1;
	localparam logic [3:0] CMD_UPDATE_DAC   = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
	localparam logic [3:0] CMD_READBACK     = 4'h9;

	// Scale codes.
	localparam logic [15:0] ZERO_CODE = 16'h0000;
	localparam logic [15:0] MID_CODE  = 16'h8000;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FRAME  = 8'h08;
	localparam logic [7:0] OFS_INPUT  = 8'h10;
	localparam logic [7:0] OFS_DAC    = 8'h20;

	// Control register fields and reset value.
	localparam int unsigned CTRL_SYNC_BIT  = 0;
	localparam int unsigned CTRL_DAISY_BIT = 1;
	localparam logic [1:0]  CTRL_RESET     = 2'h0;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Pin sampler bit positions and reset levels. The reset-pin stages start low, so
	// power-on waits until the real pin and strap levels have crossed the synchroniser.
	localparam int unsigned PIN_SCLK  = 0;
	localparam int unsigned PIN_FS    = 1;
	localparam int unsigned PIN_SIN   = 2;
	localparam int unsigned PIN_LOAD  = 3;
	localparam int unsigned PIN_CLR   = 4;
	localparam int unsigned PIN_LEVEL = 5;
	localparam int unsigned PIN_SPAN  = 6;
	localparam logic [6:0]  PIN_IDLE  = 7'h0b;

	typedef enum logic [1:0] {
		QDAC_ST_POR = 2'b00,
		QDAC_ST_RUN = 2'b01
	} qdac_state_e;

	typedef logic [3:0][15:0] qdac_codes_t;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} qdac_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} qdac_axi_rsp_s;

endpackage : qdac_pkg

// file: qdac_ctrl_monitor.sv
// Concurrent checks on the ports of the quad converter serial load control.
`timescale 1ns/10ps

module qdac_ctrl_monitor (
	input wire logic                    core_clk,           // System clock.
	input wire logic                    arst_n,             // Asynchronous reset, active low.
	input wire logic                    frame_sel_n,        // Frame select pin.
	input wire logic                    load_outputs_n,     // Load pin.
	input wire logic                    clear_n,            // Device reset pin.
	input wire logic                    reset_level_select, // Reset level pin.
	input wire logic                    span_select,        // Span pin.
	input wire qdac_pkg::qdac_codes_t   dac_codes,          // Converter codes.
	input wire logic                    span_double,        // Span output.
	input wire qdac_pkg::qdac_axi_req_s axi_req,            // Bus master side.
	input wire qdac_pkg::qdac_axi_rsp_s axi_rsp             // Bus slave side.
);
	default clocking mon_cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	logic       quiet_hold;
	logic [3:0] quiet_next;
	logic [3:0] quiet_reg;

	// Counts calm cycles on every pin that may move the codes; saturates so it never wraps.
	assign quiet_hold = frame_sel_n && load_outputs_n && clear_n;
	assign quiet_next = !quiet_hold ? 4'h0 : ((quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1);

	// Counter register.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			quiet_reg <= 4'h0;
		end else begin
			quiet_reg <= quiet_next;
		end
	end

	a_codes_quiet_hold: assert property (quiet_reg >= 4'h8 |=> $stable(dac_codes))
		else $error("converter codes moved with no frame, load or reset");
	a_clear_sets_level: assert property ($fell(clear_n) |-> ##[2:8]
		(dac_codes == (reset_level_select ? {4{qdac_pkg::MID_CODE}}
		: {4{qdac_pkg::ZERO_CODE}})))
		else $error("reset pin did not load the reset level");
	a_span_rise_follow: assert property ($rose(span_select) |-> ##[2:4] span_double)
		else $error("span output did not follow a rise");
	a_span_fall_follow: assert property ($fell(span_select) |-> ##[2:4] !span_double)
		else $error("span output did not follow a fall");
	// The commit cycle follows the edge that takes both halves, so the answer is two edges on.
	a_write_answer_next: assert property (axi_req.awvalid && axi_rsp.awready
		&& axi_req.wvalid && axi_rsp.wready |-> ##2 axi_rsp.bvalid)
		else $error("write response late");
	a_write_resp_release: assert property (axi_rsp.bvalid && axi_req.bready
		|=> !axi_rsp.bvalid ##[0:2] (axi_rsp.awready && axi_rsp.wready))
		else $error("write channel not released after response");
	a_write_blocked_busy: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write accepted while response pending");
	a_read_answer_next: assert property (axi_req.arvalid && axi_rsp.arready
		|=> axi_rsp.rvalid && !axi_rsp.arready)
		else $error("read response late");
	a_read_data_hold: assert property (axi_rsp.rvalid && !axi_req.rready
		|=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped before handshake");

endmodule : qdac_ctrl_monitor

bind qdac_ctrl qdac_ctrl_monitor u_mon (
	.core_clk          (core_clk),
	.arst_n            (arst_n),
	.frame_sel_n       (frame_sel_n),
	.load_outputs_n    (load_outputs_n),
	.clear_n           (clear_n),
	.reset_level_select(reset_level_select),
	.span_select       (span_select),
	.dac_codes         (dac_codes),
	.span_double       (span_double),
	.axi_req           (axi_req),
	.axi_rsp           (axi_rsp)
);

// file: qdac_host.sv
// Behavioural serial host that frames words into the converter and captures its output.
`timescale 1ns/10ps

module qdac_host (
	output logic      serial_clk,  // Serial clock, idle high.
	output logic      frame_sel_n, // Frame select, active low.
	output logic      serial_in,   // Data to the device.
	input  wire logic serial_out   // Data from the device.
);
	// Idle levels; the clock stands still between frames.
	initial begin
		serial_clk = 1'b1;
		frame_sel_n = 1'b1;
		serial_in = 1'b0;
	end

	task automatic send(input logic [23:0] w, input int nb, input int hp, output logic [23:0] rx);
		rx = '0;
		#7;
		frame_sel_n = 1'b0;
		#(hp);
		for (int i = 0; i < nb; i++) begin
			serial_in = w[23 - i];
			#(hp);
			serial_clk = 1'b0;
			rx = {rx[22:0], serial_out};
			#(hp);
			serial_clk = 1'b1;
		end
		#(hp);
		frame_sel_n = 1'b1;
		// A released line carries no meaning, so it is flipped rather than held.
		serial_in = ~serial_in;
		#(2 * hp);
	endtask : send

endmodule : qdac_host

// file: tb_top.sv
// Self-checking testbench for the quad converter serial load control.
`timescale 1ns/10ps

module tb_top;
	logic                    core_clk = 1'b0;
	logic                    arst_n = 1'b0;
	logic                    load_outputs_n = 1'b1;
	logic                    clear_n = 1'b1;
	logic                    reset_level_select = 1'b1;
	logic                    span_select = 1'b0;
	wire logic               serial_clk;
	wire logic               frame_sel_n;
	wire logic               serial_in;
	logic                    serial_out;
	logic                    span_double;
	qdac_pkg::qdac_codes_t   dac_codes;
	qdac_pkg::qdac_axi_req_s req = '0;
	qdac_pkg::qdac_axi_rsp_s rsp;
	logic [33:0]             exp_q[$];
	int                      fail_count = 0;
	int                      compares = 0;
	logic [23:0]             rx;
	logic [15:0]             code;

	// Clock at 40 MHz.
	always #12.5 core_clk = ~core_clk;

	qdac_ctrl dut (
		.core_clk          (core_clk),
		.arst_n            (arst_n),
		.serial_clk        (serial_clk),
		.frame_sel_n       (frame_sel_n),
		.serial_in         (serial_in),
		.load_outputs_n    (load_outputs_n),
		.clear_n           (clear_n),
		.reset_level_select(reset_level_select),
		.span_select       (span_select),
		.serial_out        (serial_out),
		.dac_codes         (dac_codes),
		.span_double       (span_double),
		.axi_req           (req),
		.axi_rsp           (rsp)
	);

	qdac_host u_host (
		.serial_clk (serial_clk),
		.frame_sel_n(frame_sel_n),
		.serial_in  (serial_in),
		.serial_out (serial_out)
	);

	task automatic chk(input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR at %0t expected %h got %h", $time, e, g);
		end
	endtask : chk

	task automatic wrap_up();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	// Responses come back in issue order, so one queue serves both response channels.
	always @(posedge core_clk) begin
		if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
			if (exp_q.size() == 0) begin
				chk(64'h1, 64'h0);
			end else begin
				chk({30'h0, exp_q.pop_front()},
					rsp.bvalid ? {30'h0, rsp.bresp, 32'h0} : {30'h0, rsp.rresp, rsp.rdata});
			end
		end
	end

	// Bus write: address and data offered together, each dropped when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		exp_q.push_back({r, 32'h0});
		@(posedge core_clk);
		req.awaddr <= {24'h0, a};
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (!(rsp.bvalid && req.bready) && n < 100);
		req.bready <= 1'b0;
		if (n >= 100) fail_count++;
	endtask : wr

	// Bus read: ready is raised late on purpose so the slave must hold its data.
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		exp_q.push_back({r, d});
		@(posedge core_clk);
		req.araddr <= {24'h0, a};
		req.arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (!req.arvalid && rsp.rvalid && !req.rready) req.rready <= 1'b1;
		end while (!(rsp.rvalid && req.rready) && n < 100);
		req.rready <= 1'b0;
		if (n >= 100) fail_count++;
	endtask : rd

	task automatic frame(input logic [23:0] w, input int nb, input int hp);
		u_host.send(w, nb, hp, rx);
		repeat (8) @(posedge core_clk);
	endtask : frame

	task automatic pin_load(input logic v);
		@(posedge core_clk);
		load_outputs_n <= v;
		repeat (8) @(posedge core_clk);
	endtask : pin_load

	// Main sequence.
	initial begin
		void'($urandom(24993));
		code = 16'($urandom);
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (12) @(posedge core_clk);
		chk({4{qdac_pkg::MID_CODE}}, dac_codes);
		rd(qdac_pkg::OFS_DAC, 32'h0000_8000, qdac_pkg::RESP_OKAY);
		rd(qdac_pkg::OFS_CTRL, '0, qdac_pkg::RESP_OKAY);
		rd(8'h40, '0, qdac_pkg::RESP_SLVERR);
		wr(8'h40, 32'h0000_0003, qdac_pkg::RESP_SLVERR);
		frame({qdac_pkg::CMD_WRITE_INPUT, 4'hf, code}, 24, 100);
		rd(qdac_pkg::OFS_INPUT + 8'h0c, {16'h0, code}, qdac_pkg::RESP_OKAY);
		chk({4{qdac_pkg::MID_CODE}}, dac_codes);
		pin_load(1'b0);
		pin_load(1'b1);
		chk({4{code}}, dac_codes);
		frame({qdac_pkg::CMD_WRITE_UPDATE, 4'hf, ~code}, 23, 100);
		chk({4{code}}, dac_codes);
		frame({qdac_pkg::CMD_WRITE_INPUT, 4'h2, ~code}, 24, 100);
		frame({qdac_pkg::CMD_UPDATE_DAC, 4'h2, 16'h0}, 24, 100);
		frame({qdac_pkg::CMD_WRITE_UPDATE, 4'h8, ~code}, 24, 100);
		chk({~code, code, ~code, code}, dac_codes);
		@(posedge core_clk);
		reset_level_select <= 1'b0;
		repeat (4) @(posedge core_clk);
		clear_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk('0, dac_codes);
		frame({qdac_pkg::CMD_WRITE_INPUT, 4'hf, code}, 24, 100);
		pin_load(1'b0);
		pin_load(1'b1);
		chk('0, dac_codes);
		clear_n <= 1'b1;
		pin_load(1'b0);
		frame({qdac_pkg::CMD_WRITE_INPUT, 4'hf, 16'hffff}, 24, 100);
		chk({4{16'hffff}}, dac_codes);
		wr(qdac_pkg::OFS_CTRL, 32'h0000_0001, qdac_pkg::RESP_OKAY);
		frame({qdac_pkg::CMD_WRITE_INPUT, 4'h1, code}, 24, 100);
		chk({{3{16'hffff}}, code}, dac_codes);
		pin_load(1'b1);
		frame({qdac_pkg::CMD_WRITE_INPUT, 4'h2, code}, 24, 100);
		pin_load(1'b0);
		chk({{3{16'hffff}}, code}, dac_codes);
		frame({qdac_pkg::CMD_WRITE_INPUT, 4'h4, code}, 24, 100);
		chk({16'hffff, {3{code}}}, dac_codes);
		wr(qdac_pkg::OFS_CTRL, '0, qdac_pkg::RESP_OKAY);
		frame({qdac_pkg::CMD_READBACK, 4'h1, 16'h0}, 24, 100);
		frame(24'h0, 24, 100);
		chk({40'h0, 8'h00, code}, {40'h0, rx});
		wr(qdac_pkg::OFS_CTRL, 32'h0000_0002, qdac_pkg::RESP_OKAY);
		frame({8'h00, ~code}, 24, 100);
		frame(24'h0, 24, 100);
		chk({40'h0, 8'h00, ~code}, {40'h0, rx});
		@(posedge core_clk);
		span_select <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk(64'h1, {63'h0, span_double});
		span_select <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk(64'h0, {63'h0, span_double});
		clear_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		reset_level_select <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk('0, dac_codes);
		clear_n <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk({4{qdac_pkg::MID_CODE}}, dac_codes);
		wrap_up();
	end

	// Watchdog well beyond the hundred or so microseconds the sequence needs.
	initial begin
		#2_000_000;
		fail_count++;
		wrap_up();
	end

endmodule : tb_top
